// ### common/tcu_defs.vh
`ifndef TCU_DEFS_VH
`define TCU_DEFS_VH

// byte write selects for the counter and reload bytes
`define TCU_SEL_T0L 3'h0
`define TCU_SEL_T0H 3'h1
`define TCU_SEL_T1L 3'h2
`define TCU_SEL_T1H 3'h3
`define TCU_SEL_T2L 3'h4
`define TCU_SEL_T2H 3'h5
`define TCU_SEL_RLL 3'h6
`define TCU_SEL_RLH 3'h7

// timer 0/1 mode codes (mode_bit_high, mode_bit_low)
`define TCU_MODE_13 2'h0
`define TCU_MODE_16 2'h1
`define TCU_MODE_AR8 2'h2
`define TCU_MODE_SPLIT 2'h3

// timer_mode_register field positions
`define TCU_T0_MODE_LO 0
`define TCU_T0_MODE_HI 1
`define TCU_T0_CT 2
`define TCU_T0_GATE 3
`define TCU_T1_MODE_LO 4
`define TCU_T1_MODE_HI 5
`define TCU_T1_CT 6
`define TCU_T1_GATE 7

// timer_control_register bit positions owned by this unit
`define TCU_CTRL_RUN0 4
`define TCU_CTRL_OVF0 5
`define TCU_CTRL_RUN1 6
`define TCU_CTRL_OVF1 7
`define TCU_CTRL_RST 8'h00

// counting constants
`define TCU_TICK12_LAST 4'hB
`define TCU_TICK12_ZERO 4'h0
`define TCU_PRESC_LAST 5'h1F
`define TCU_PRESC_ZERO 5'h00
`define TCU_BYTE_MAX 8'hFF
`define TCU_BYTE_ZERO 8'h00
`define TCU_BYTE_ONE 8'h01
`define TCU_WORD_MAX 16'hFFFF
`define TCU_WORD_ONE 16'h0001
`define TCU_WORD_ZERO 16'h0000

// capture/direction pin level, fixed inside the device
`define TCU_DIR_PIN_TIED 1'b1
// synchroniser reset level: a pin high after reset gives no false fall
`define TCU_PIN_RST 1'b0

// synchronised pin indices
`define TCU_NUM_PINS 5
`define TCU_PIN_T0 0
`define TCU_PIN_T1 1
`define TCU_PIN_T2 2
`define TCU_PIN_IRQ0 3
`define TCU_PIN_IRQ1 4

`endif

// ### design/tcu_pin_sync.v
`timescale 1ns/1ps
`include "tcu_defs.vh"

// two-flop synchroniser plus falling-edge detector for one input pin
module tcu_pin_sync (
  input wire core_clk,
  input wire srst,
  input wire pin_in,
  output wire pin_level,
  output wire pin_fall
);
  reg meta; // first stage, read only by the second stage
  reg stable; // synchronised level
  reg prev; // last synchronised level, for edge detection

  // edge is taken between stable stages, never from the metastable one
  always @(posedge core_clk) begin
    if (srst) begin
      meta <= `TCU_PIN_RST;
      stable <= `TCU_PIN_RST;
      prev <= `TCU_PIN_RST;
    end else begin
      meta <= pin_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign pin_level = stable;
  assign pin_fall = prev & ~stable;
endmodule // tcu_pin_sync

// ### design/tcu_top.v
`timescale 1ns/1ps
`include "tcu_defs.vh"

// How it works
// RULE_01: mode 0: 5-bit prescaler feeds high byte
// RULE_02: mode 1: low and high cascaded 16-bit
// RULE_03: mode 2: low byte reloads from high
// RULE_04: timer 0 flag cleared on interrupt service
// RULE_05: mode 3: timer 0 low byte normal 8-bit
// RULE_06: mode 3 high byte: tick, timer 1 run/flag
// RULE_07: timer 1 modes 0-2 mirror timer 0
// RULE_08: timer 1 uses upper mode nibble, control bits
// RULE_09: gate set: interrupt pin also gates counting
// RULE_10: timer 1 mode 3 holds its count
// RULE_11: timer 2 counts tick or count pin
// RULE_12: timer 2 mode decode, baud has priority
// RULE_13: capture mode: overflow flag, edge captures count
// RULE_14: both timer 2 flags raise its interrupt
// RULE_15: timer 2 counts only with run set
// RULE_16: down-count enable resets to zero; here it is a port input with no reset
// RULE_17: up auto-reload: overflow sets flag, reloads
// RULE_18: external edge also reloads, sets external flag
// RULE_19: up/down, pin high: count up, reload
// RULE_20: pin low: down, underflow at reload, load FFFF
// RULE_21: up/down: external flag toggles, no interrupt
// RULE_22: clock-out: half clock, reload, 50% clock
// RULE_23: capture/direction pin tied high internally
// RULE_24: timer 0 uses low nibble, control bits
// RULE_25: software clears both timer 2 flags
// RULE_26: baud mode reloads without overflow flag
// RULE_27: gate pin sampled synchronously, high counts
// RULE_28: count pin advances once per falling edge
module tcu_top (
  input wire core_clk,
  input wire srst,
  input wire [7:0] timer_mode_register,
  input wire t0_run_bit,
  input wire t1_run_bit,
  input wire t2_run_bit,
  input wire t2_counter_select,
  input wire capture_reload_select,
  input wire clock_out_enable,
  input wire down_count_enable,
  input wire rx_baud_clock_select,
  input wire tx_baud_clock_select,
  input wire t2_external_enable,
  input wire wr_strobe,
  input wire [2:0] wr_sel,
  input wire [7:0] wr_data,
  input wire t0_irq_taken,
  input wire t1_irq_taken,
  input wire t0_flag_clear,
  input wire t1_flag_clear,
  input wire t2_overflow_clear,
  input wire t2_external_clear,
  input wire t0_count_pin,
  input wire t1_count_pin,
  input wire t2_count_pin,
  input wire ext_irq0_pin,
  input wire ext_irq1_pin,
  output reg [7:0] t0_low_byte,
  output reg [7:0] t0_high_byte,
  output reg [7:0] t1_low_byte,
  output reg [7:0] t1_high_byte,
  output reg [7:0] t2_low_byte,
  output reg [7:0] t2_high_byte,
  output reg [7:0] t2_reload_low,
  output reg [7:0] t2_reload_high,
  output reg t0_overflow_flag,
  output reg t1_overflow_flag,
  output reg t2_overflow_flag,
  output reg t2_external_flag,
  output reg t2_irq,
  output reg [7:0] timer_control_register,
  output reg t2_clock_out,
  output reg t1_baud_tick,
  output reg t2_baud_tick
);

  // one step of an 8-bit pair in modes 0..2; mode 3 gives the low byte only
  // result is {overflow, high, low}
  function [16:0] tcu_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg [16:0] r;
    begin
      r = {1'b0, hi, lo};
      case (mode)
        `TCU_MODE_13: begin
          // upper three low-byte bits are left alone
          if (lo[4:0] == `TCU_PRESC_LAST) begin
            r[4:0] = `TCU_PRESC_ZERO;
            r[15:8] = hi + `TCU_BYTE_ONE;
            r[16] = (hi == `TCU_BYTE_MAX);
          end else begin
            r[4:0] = lo[4:0] + 5'h01;
          end // [RULE_01]
        end
        `TCU_MODE_16: begin
          r = {1'b0, hi, lo} + {1'b0, `TCU_WORD_ONE}; // carry out is overflow [RULE_02]
        end
        `TCU_MODE_AR8: begin
          if (lo == `TCU_BYTE_MAX) begin
            r[7:0] = hi; // reload, high byte untouched
            r[16] = 1'b1;
          end else begin
            r[7:0] = lo + `TCU_BYTE_ONE;
          end // [RULE_03]
        end
        default: begin
          r[7:0] = lo + `TCU_BYTE_ONE; // split low half wraps [RULE_05]
          r[16] = (lo == `TCU_BYTE_MAX);
        end
      endcase
      tcu_step = r;
    end
  endfunction

  // ---- pin synchronisers, one per external pin ----
  wire [`TCU_NUM_PINS-1:0] pin_raw; // raw pins
  wire [`TCU_NUM_PINS-1:0] pin_level; // synchronised levels
  wire [`TCU_NUM_PINS-1:0] pin_fall; // falling-edge pulses
  assign pin_raw = {ext_irq1_pin, ext_irq0_pin, t2_count_pin, t1_count_pin, t0_count_pin};

  genvar gi;
  generate
    for (gi = 0; gi < `TCU_NUM_PINS; gi = gi + 1) begin : g_pin
      tcu_pin_sync u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .pin_in(pin_raw[gi]),
        .pin_level(pin_level[gi]),
        .pin_fall(pin_fall[gi])
      );
    end
  endgenerate

  // ---- time base: divide-by-12 tick and half-rate tick ----
  reg [3:0] div12; // cycles within the 12-cycle period
  reg half; // toggles every cycle
  wire tick12 = (div12 == `TCU_TICK12_LAST);

  always @(posedge core_clk) begin
    if (srst) begin
      div12 <= `TCU_TICK12_ZERO;
      half <= 1'b0;
    end else begin
      div12 <= tick12 ? `TCU_TICK12_ZERO : div12 + 4'h1;
      half <= ~half;
    end
  end

  // ---- timer 0/1 configuration decode ----
  wire [1:0] mode0 = {timer_mode_register[`TCU_T0_MODE_HI], timer_mode_register[`TCU_T0_MODE_LO]}; // [RULE_24]
  wire [1:0] mode1 = {timer_mode_register[`TCU_T1_MODE_HI], timer_mode_register[`TCU_T1_MODE_LO]}; // [RULE_08]
  wire split0 = (mode0 == `TCU_MODE_SPLIT);
  wire hold1 = (mode1 == `TCU_MODE_SPLIT);

  // source: divided tick or one count per synchronised falling edge
  wire src0 = timer_mode_register[`TCU_T0_CT] ? pin_fall[`TCU_PIN_T0] : tick12; // [RULE_28]
  wire src1 = timer_mode_register[`TCU_T1_CT] ? pin_fall[`TCU_PIN_T1] : tick12; // [RULE_28]
  // gate open when gating is off or the synchronised interrupt pin is high
  wire gate0 = ~timer_mode_register[`TCU_T0_GATE] | pin_level[`TCU_PIN_IRQ0]; // [RULE_09] [RULE_27]
  wire gate1 = ~timer_mode_register[`TCU_T1_GATE] | pin_level[`TCU_PIN_IRQ1]; // [RULE_09] [RULE_27]

  // while timer 0 is split its high half owns timer 1's run bit, so timer 1
  // runs free there and its overflow only feeds the baud tick
  wire run1 = split0 | t1_run_bit;
  wire inc0 = t0_run_bit & gate0 & src0; // [RULE_24] [RULE_05]
  wire inc1 = ~hold1 & run1 & gate1 & src1; // [RULE_10] [RULE_07]
  wire inc0_high = split0 & t1_run_bit & tick12; // [RULE_06]

  wire [16:0] step0 = inc0 ? tcu_step(mode0, t0_low_byte, t0_high_byte) : {1'b0, t0_high_byte, t0_low_byte};
  wire [16:0] step1 = inc1 ? tcu_step(mode1, t1_low_byte, t1_high_byte) : {1'b0, t1_high_byte, t1_low_byte}; // [RULE_07]
  wire ovf0_high = inc0_high & (t0_high_byte == `TCU_BYTE_MAX);

  wire set_flag0 = step0[16];
  wire set_flag1 = split0 ? ovf0_high : step1[16]; // [RULE_06]

  // byte write decode
  wire wr_t0l = wr_strobe & (wr_sel == `TCU_SEL_T0L);
  wire wr_t0h = wr_strobe & (wr_sel == `TCU_SEL_T0H);
  wire wr_t1l = wr_strobe & (wr_sel == `TCU_SEL_T1L);
  wire wr_t1h = wr_strobe & (wr_sel == `TCU_SEL_T1H);
  wire wr_t2l = wr_strobe & (wr_sel == `TCU_SEL_T2L);
  wire wr_t2h = wr_strobe & (wr_sel == `TCU_SEL_T2H);
  wire wr_rll = wr_strobe & (wr_sel == `TCU_SEL_RLL);
  wire wr_rlh = wr_strobe & (wr_sel == `TCU_SEL_RLH);

  // next flags: a set in the same cycle as a clear wins
  wire next_flag0 = set_flag0 | (t0_overflow_flag & ~(t0_irq_taken | t0_flag_clear)); // [RULE_04]
  wire next_flag1 = set_flag1 | (t1_overflow_flag & ~(t1_irq_taken | t1_flag_clear));

  // timers 0 and 1: software byte writes override counting in that cycle
  always @(posedge core_clk) begin
    if (srst) begin
      t0_low_byte <= `TCU_BYTE_ZERO;
      t0_high_byte <= `TCU_BYTE_ZERO;
      t1_low_byte <= `TCU_BYTE_ZERO;
      t1_high_byte <= `TCU_BYTE_ZERO;
      t0_overflow_flag <= 1'b0;
      t1_overflow_flag <= 1'b0;
      t1_baud_tick <= 1'b0;
    end else begin
      t0_low_byte <= wr_t0l ? wr_data : step0[7:0];
      if (wr_t0h) begin
        t0_high_byte <= wr_data;
      end else if (split0) begin
        t0_high_byte <= inc0_high ? t0_high_byte + `TCU_BYTE_ONE : t0_high_byte; // [RULE_06]
      end else begin
        t0_high_byte <= step0[15:8];
      end
      t1_low_byte <= wr_t1l ? wr_data : step1[7:0];
      t1_high_byte <= wr_t1h ? wr_data : step1[15:8];
      t0_overflow_flag <= next_flag0;
      t1_overflow_flag <= next_flag1;
      t1_baud_tick <= step1[16];
    end
  end

  // ---- timer 2 mode decode ----
  wire t2_baud = rx_baud_clock_select | tx_baud_clock_select; // [RULE_12]
  wire t2_cap = ~t2_baud & capture_reload_select;
  wire t2_clkout = ~t2_baud & ~capture_reload_select & clock_out_enable;
  wire t2_auto = ~t2_baud & ~capture_reload_select & ~clock_out_enable;
  // down-count enable comes straight from its input with no reset, so plain auto-reload needs it driven low
  wire t2_updown = t2_auto & down_count_enable; // [RULE_16]

  // the capture/direction pin never leaves its high level, so no falling
  // edge is seen and up/down mode always counts up
  wire dir_pin_level = `TCU_DIR_PIN_TIED; // [RULE_23]
  reg dir_pin_prev; // previous level for edge detection
  wire dir_pin_fall = dir_pin_prev & ~dir_pin_level;
  wire t2_ext = t2_external_enable & dir_pin_fall;

  // baud and clock-out modes count at half the core clock
  wire t2_src = (t2_baud | t2_clkout) ? half : (t2_counter_select ? pin_fall[`TCU_PIN_T2] : tick12); // [RULE_11]
  wire t2_inc = t2_run_bit & t2_src; // [RULE_15]
  wire count_down = t2_updown & ~dir_pin_level; // [RULE_20]
  wire [15:0] cnt2 = {t2_high_byte, t2_low_byte};
  wire [15:0] rl2 = {t2_reload_high, t2_reload_low};
  wire t2_ovf = t2_inc & ~count_down & (cnt2 == `TCU_WORD_MAX);
  wire t2_unf = t2_inc & count_down & (cnt2 == rl2);

  reg [15:0] next_cnt2; // counter after this cycle's event
  reg [15:0] next_rl2; // reload/capture after this cycle's event
  reg set_flag2; // overflow flag set request
  reg set_ext2; // external flag set request
  reg tog_ext2; // external flag toggle in up/down mode

  // timer 2 next-state by mode
  always @* begin
    next_rl2 = rl2;
    set_flag2 = 1'b0;
    set_ext2 = 1'b0;
    tog_ext2 = 1'b0;
    if (t2_inc) begin
      next_cnt2 = count_down ? cnt2 - `TCU_WORD_ONE : cnt2 + `TCU_WORD_ONE;
    end else begin
      next_cnt2 = cnt2;
    end
    if (t2_cap) begin
      set_flag2 = t2_ovf; // counter wraps to zero
      if (t2_ext) begin
        next_rl2 = cnt2; // [RULE_13]
        set_ext2 = 1'b1;
      end
    end else if (t2_updown) begin
      if (t2_ovf) begin
        next_cnt2 = rl2; // [RULE_19]
        set_flag2 = 1'b1;
        tog_ext2 = 1'b1;
      end else if (t2_unf) begin
        next_cnt2 = `TCU_WORD_MAX; // [RULE_20]
        set_flag2 = 1'b1;
        tog_ext2 = 1'b1; // [RULE_21]
      end
    end else if (t2_auto) begin
      if (t2_ovf | t2_ext) begin
        next_cnt2 = rl2; // [RULE_17] [RULE_18]
      end
      set_flag2 = t2_ovf; // [RULE_17]
      set_ext2 = t2_ext; // [RULE_18]
    end else if (t2_baud) begin
      if (t2_ovf) begin
        next_cnt2 = rl2; // no overflow flag here [RULE_26]
      end
      set_ext2 = t2_ext;
    end else begin
      if (t2_ovf) begin
        next_cnt2 = rl2; // clock-out reload, no flags [RULE_22]
      end
    end
  end

  // flags stay until software clears them, except the external flag that up/down mode toggles; a set beats a same-cycle clear
  wire next_flag2 = set_flag2 | (t2_overflow_flag & ~t2_overflow_clear); // [RULE_25]
  wire next_ext2 = tog_ext2 ? ~t2_external_flag : (set_ext2 | (t2_external_flag & ~t2_external_clear)); // [RULE_21]

  // timer 2 registers, interrupt and outputs
  always @(posedge core_clk) begin
    if (srst) begin
      t2_low_byte <= `TCU_BYTE_ZERO;
      t2_high_byte <= `TCU_BYTE_ZERO;
      t2_reload_low <= `TCU_BYTE_ZERO;
      t2_reload_high <= `TCU_BYTE_ZERO;
      t2_overflow_flag <= 1'b0;
      t2_external_flag <= 1'b0;
      t2_irq <= 1'b0;
      t2_clock_out <= 1'b0;
      t2_baud_tick <= 1'b0;
      dir_pin_prev <= `TCU_DIR_PIN_TIED;
    end else begin
      t2_low_byte <= wr_t2l ? wr_data : next_cnt2[7:0];
      t2_high_byte <= wr_t2h ? wr_data : next_cnt2[15:8];
      t2_reload_low <= wr_rll ? wr_data : next_rl2[7:0];
      t2_reload_high <= wr_rlh ? wr_data : next_rl2[15:8];
      t2_overflow_flag <= next_flag2;
      t2_external_flag <= next_ext2;
      // external flag is a 17th count bit in up/down mode, not a request
      t2_irq <= next_flag2 | (next_ext2 & ~t2_updown); // [RULE_14] [RULE_21]
      // toggle per overflow gives core / (4 x (65536 - reload)), 50% duty
      if (t2_clkout) begin
        t2_clock_out <= t2_ovf ? ~t2_clock_out : t2_clock_out; // [RULE_22]
      end else begin
        t2_clock_out <= 1'b0;
      end
      t2_baud_tick <= t2_ovf & t2_baud; // [RULE_26]
      dir_pin_prev <= dir_pin_level;
    end
  end

  // control register image: flags and run bits; external-interrupt bits
  // belong to the interrupt unit and read as zero here
  reg [7:0] next_ctrl; // image computed from next flag values
  always @* begin
    next_ctrl = `TCU_CTRL_RST;
    next_ctrl[`TCU_CTRL_RUN0] = t0_run_bit;
    next_ctrl[`TCU_CTRL_OVF0] = next_flag0;
    next_ctrl[`TCU_CTRL_RUN1] = t1_run_bit;
    next_ctrl[`TCU_CTRL_OVF1] = next_flag1; // [RULE_08]
  end

  always @(posedge core_clk) begin
    if (srst) begin
      timer_control_register <= `TCU_CTRL_RST;
    end else begin
      timer_control_register <= next_ctrl;
    end
  end
endmodule // tcu_top

// ### dv/tcu_monitor.sv
`timescale 1ns/1ps
// port-level checks of the timer unit
module tcu_monitor (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic t0_run_bit,
  input wire logic t2_run_bit,
  input wire logic t0_irq_taken,
  input wire logic down_count_enable,
  input wire logic rx_baud_clock_select,
  input wire logic tx_baud_clock_select,
  input wire logic wr_strobe,
  input wire logic [2:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] t2_low_byte,
  input wire logic [7:0] t2_high_byte,
  input wire logic [7:0] t2_reload_low,
  input wire logic t0_overflow_flag,
  input wire logic t1_overflow_flag,
  input wire logic t2_overflow_flag,
  input wire logic t2_external_flag,
  input wire logic t2_irq,
  input wire logic [7:0] timer_control_register
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_ctrl_flags: assert property (
    timer_control_register[5] == t0_overflow_flag && timer_control_register[7] == t1_overflow_flag
    && timer_control_register[3:0] == 4'h0) else $error("control byte flags wrong");
  a_ctrl_run: assert property (
    !$past(srst) |-> timer_control_register[4] == $past(t0_run_bit)) else $error("control run bit wrong");
  a_t0_svc_clear: assert property (
    t0_irq_taken && !t0_run_bit |=> !t0_overflow_flag) else $error("t0 flag kept");
  a_t2_irq_src: assert property (
    t2_overflow_flag |-> t2_irq) else $error("t2 irq missing");
  a_ext_flag_tied: assert property (
    $rose(t2_external_flag) |-> $past(down_count_enable)) else $error("t2 external flag set");
  a_baud_no_flag: assert property (
    $rose(t2_overflow_flag) |-> !$past(rx_baud_clock_select) && !$past(tx_baud_clock_select))
    else $error("t2 flag in baud mode");
  a_t2_run_hold: assert property (
    (!t2_run_bit && !wr_strobe) ##1 !t2_run_bit |-> $stable({t2_high_byte, t2_low_byte}))
    else $error("t2 counted while stopped");
  a_reload_load: assert property (
    wr_strobe && wr_sel == 3'h6 |=> t2_reload_low == $past(wr_data)) else $error("reload low not written");
endmodule // tcu_monitor

bind tcu_top tcu_monitor i_tcu_monitor (.*);

// ### dv/tcu_pin_model.sv
`timescale 1ns/1ps
// far side: count pins idle high, one clean low pulse per request
module tcu_pin_model (
  input wire core_clk,
  input wire [2:0] fall_req,
  input wire [1:0] gate_req,
  output reg [2:0] count_pin,
  output reg [1:0] gate_pin
);
  reg [1:0] low_left [0:2]; // cycles a pin still stays low
  integer i;
  initial begin
    count_pin = 3'h7;
    gate_pin = 2'h0;
    for (i = 0; i < 3; i = i + 1) low_left[i] = 2'h0;
  end
  // each level lasts several cycles so the synchroniser sees one fall
  always @(posedge core_clk) begin
    gate_pin <= gate_req;
    for (i = 0; i < 3; i = i + 1) begin
      if (fall_req[i]) begin
        count_pin[i] <= 1'b0;
        low_left[i] <= 2'h3;
      end else if (low_left[i] != 2'h0) begin
        low_left[i] <= low_left[i] - 2'h1;
      end else begin
        count_pin[i] <= 1'b1;
      end
    end
  end
endmodule // tcu_pin_model

// ### dv/tcu_tb_top.sv
`timescale 1ns/1ps
// self-checking bench: drivers note expectations, one process compares
module tcu_tb_top;
  logic core_clk = 0, srst = 1, wr_strobe = 0;
  logic [7:0] timer_mode_register = 0, wr_data = 0;
  logic [2:0] wr_sel = 0, fall_req = 0;
  logic [1:0] gate_req = 0;
  logic t0_run_bit = 0, t1_run_bit = 0, t2_run_bit = 0, t2_counter_select = 0, capture_reload_select = 0;
  logic clock_out_enable = 0, down_count_enable = 0, rx_baud_clock_select = 0, tx_baud_clock_select = 0;
  logic t2_external_enable = 0, t0_irq_taken = 0, t1_irq_taken = 0, t0_flag_clear = 0, t1_flag_clear = 0;
  logic t2_overflow_clear = 0, t2_external_clear = 0;
  wire t0_count_pin, t1_count_pin, t2_count_pin, ext_irq0_pin, ext_irq1_pin;
  wire [7:0] t0_low_byte, t0_high_byte, t1_low_byte, t1_high_byte, t2_low_byte, t2_high_byte;
  wire [7:0] t2_reload_low, t2_reload_high, timer_control_register;
  wire t0_overflow_flag, t1_overflow_flag, t2_overflow_flag, t2_external_flag, t2_irq;
  wire t2_clock_out, t1_baud_tick, t2_baud_tick;
  wire [4:0] evs = {t2_clock_out, t2_baud_tick, t2_overflow_flag, t1_overflow_flag, t0_overflow_flag};
  int err_total = 0, checked = 0, seed = 46279;
  int id_q[$];
  logic [15:0] ex_q[$];
  event chk_ev;
  string nm[9] = '{"t0 count", "t1 count", "t2 count", "flags", "t2 irq", "control", "clock out", "t1 baud tick",
    "reload"};

  tcu_top i_tcu_top (.*);
  tcu_pin_model i_tcu_pin_model (.core_clk(core_clk), .fall_req(fall_req), .gate_req(gate_req),
    .count_pin({t2_count_pin, t1_count_pin, t0_count_pin}), .gate_pin({ext_irq1_pin, ext_irq0_pin}));

  initial forever #2.5 core_clk = ~core_clk;

  // observed value for each checked item
  function automatic logic [15:0] obs(input int id);
    case (id)
      0: return {t0_high_byte, t0_low_byte};
      1: return {t1_high_byte, t1_low_byte};
      2: return {t2_high_byte, t2_low_byte};
      3: return {12'h000, t0_overflow_flag, t1_overflow_flag, t2_overflow_flag, t2_external_flag};
      4: return {15'h0000, t2_irq};
      5: return {8'h00, timer_control_register};
      6: return {15'h0000, t2_clock_out};
      7: return {15'h0000, t1_baud_tick};
      default: return {t2_reload_high, t2_reload_low};
    endcase
  endfunction
  task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task note(input int id, input logic [15:0] v);
    id_q.push_back(id);
    ex_q.push_back(v);
    -> chk_ev;
  endtask
  // comparer: oldest note against the settled outputs
  always begin : cmp
    int id;
    @(chk_ev);
    while (id_q.size() > 0) begin
      id = id_q.pop_front();
      check(nm[id], obs(id), ex_q.pop_front());
    end
  end
  // all drive happens 1 ns after the rising edge
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // strobe stays high across both bytes so it is never set twice in a step
  task w16(input logic [2:0] s, input logic [15:0] v);
    wr_strobe = 1;
    wr_sel = s;
    wr_data = v[7:0];
    cyc(1);
    wr_sel = s + 3'h1;
    wr_data = v[15:8];
    cyc(1);
    wr_strobe = 0;
    cyc(1);
  endtask
  task wait_hi(input int b, input int lim);
    int n;
    n = 0;
    while (evs[b] !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    check("event", {15'h0000, evs[b]}, 16'h0001);
  endtask
  task pulse;
    fall_req = 3'h7;
    cyc(1);
    fall_req = 3'h0;
    cyc(8);
  endtask
  task conclude;
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // the tests need fewer than 300 cycles; twenty thousand means a hang
  initial begin
    #(20000 * 5);
    err_total++;
    conclude();
  end

  initial begin
    logic [15:0] rl;
    int b;
    rl = 16'($random(seed));
    cyc(8);
    srst = 0;
    cyc(3);
    timer_mode_register = 8'h01;
    w16(3'h0, 16'hFFFF);
    t0_run_bit = 1;
    wait_hi(0, 30);
    note(0, 16'h0000);
    note(5, 16'h0030);
    t0_run_bit = 0;
    t0_irq_taken = 1;
    cyc(1);
    t0_irq_taken = 0;
    note(3, 16'h0000);
    // 13-bit: top three low bits keep their written value
    timer_mode_register = 8'h00;
    w16(3'h0, 16'hFFFF);
    t0_run_bit = 1;
    wait_hi(0, 30);
    note(0, 16'h00E0);
    t0_run_bit = 0;
    t0_flag_clear = 1;
    cyc(1);
    t0_flag_clear = 0;
    timer_mode_register = 8'h20;
    w16(3'h2, {rl[7:0], 8'hFE});
    t1_run_bit = 1;
    wait_hi(1, 40);
    note(1, {rl[7:0], rl[7:0]});
    note(7, 16'h0001);
    t1_run_bit = 0;
    t1_irq_taken = 1;
    cyc(1);
    t1_irq_taken = 0;
    // split timer 0 borrows the timer 1 run bit and flag; timer 1 halted
    timer_mode_register = 8'h33;
    w16(3'h0, 16'hFF00);
    t1_run_bit = 1;
    wait_hi(1, 30);
    note(0, 16'h0000);
    note(3, 16'h0004);
    note(1, {rl[7:0], rl[7:0]});
    t1_run_bit = 0;
    t1_irq_taken = 1;
    cyc(1);
    t1_irq_taken = 0;
    // pin counting, timer 1 gated by its interrupt pin
    timer_mode_register = 8'hD5;
    w16(3'h0, 16'h0000);
    w16(3'h2, 16'h0000);
    w16(3'h4, 16'h0000);
    t2_counter_select = 1;
    {t0_run_bit, t1_run_bit, t2_run_bit} = 3'h7;
    pulse();
    pulse();
    gate_req = 2'h3;
    cyc(3);
    pulse();
    note(0, 16'h0003);
    note(1, 16'h0001);
    note(2, 16'h0003);
    {t0_run_bit, t1_run_bit, t2_run_bit, t2_counter_select} = 4'h0;
    // up auto-reload, up/down, then capture; the external edge never comes
    t2_external_enable = 1;
    for (b = 0; b < 3; b++) begin
      down_count_enable = b[0];
      capture_reload_select = b[1];
      w16(3'h6, rl);
      w16(3'h4, 16'hFFFF);
      t2_run_bit = 1;
      wait_hi(2, 30);
      note(2, b[1] ? 16'h0000 : rl);
      note(3, {14'h0000, 1'b1, b[0]});
      note(4, 16'h0001);
      note(8, rl);
      t2_run_bit = 0;
      t2_overflow_clear = 1;
      cyc(1);
      t2_overflow_clear = 0;
      note(4, 16'h0000);
      t2_external_clear = 1;
      cyc(1);
      t2_external_clear = 0;
    end
    {down_count_enable, capture_reload_select, t2_external_enable} = 3'h0;
    for (b = 1; b < 4; b++) begin
      {rx_baud_clock_select, tx_baud_clock_select} = b[1:0];
      w16(3'h6, 16'hFFFE);
      w16(3'h4, 16'hFFFF);
      t2_run_bit = 1;
      wait_hi(3, 10);
      note(2, 16'hFFFE);
      note(3, 16'h0000);
      t2_run_bit = 0;
    end
    {rx_baud_clock_select, tx_baud_clock_select} = 2'h0;
    // reload FFFF gives a four-cycle output period
    clock_out_enable = 1;
    w16(3'h6, 16'hFFFF);
    w16(3'h4, 16'hFFFF);
    t2_run_bit = 1;
    wait_hi(4, 10);
    for (b = 0; b < 4; b++) begin
      cyc(1);
      note(6, {15'h0000, b == 0 || b == 3});
    end
    note(3, 16'h0000);
    t2_run_bit = 0;
    clock_out_enable = 0;
    cyc(4);
    conclude();
  end
endmodule // tcu_tb_top
